//--- hdl/aaov_pkg.sv
package aaov_pkg;

  // ==========================================================================
  // Register offsets (byte addresses, word index * 4)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_ACTION   = 8'h08;
  localparam logic [7:0] OFS_ALARM_IN = 8'h0c;
  localparam logic [7:0] OFS_PAGE     = 8'h10;
  localparam logic [7:0] OFS_LOG      = 8'h14;
  localparam logic [7:0] OFS_INDMAP   = 8'h18;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_LAMP_EN    = 0;
  localparam int CTRL_OVR_PERM   = 1;
  localparam int CTRL_OVR_SWITCH = 2;
  localparam int CTRL_OVR_WARN   = 3;
  localparam int CTRL_LATCH_WARN = 4;
  localparam int CTRL_LOG_EN     = 5;
  localparam int CTRL_CAN_EN     = 6;
  localparam int CTRL_MUTE       = 7;
  localparam int CTRL_RESET_WARN = 8;
  localparam int CTRL_LOG_POP    = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Actions of engine controller categories, two bits each
  localparam logic [1:0] ACT_NONE  = 2'h0;
  localparam logic [1:0] ACT_WARN  = 2'h1;
  localparam logic [1:0] ACT_TRIP  = 2'h2;
  localparam logic [1:0] ACT_SHUT  = 2'h3;
  // amber, red, malfunction, protect, water in fuel, after treatment
  localparam logic [11:0] ACTION_RESET = 12'h3d1;

  // Alarm sources
  localparam int SRC_COUNT = 16;
  localparam int SRC_ESTOP = 0;
  localparam int SRC_OVRSW = 1;
  localparam int SRC_LINK  = 2;
  localparam int SRC_ECUW  = 3;
  localparam int SRC_ECUS  = 4;
  localparam int SRC_DM1   = 5;

  // Alarm classes
  localparam logic [1:0] CLS_IND  = 2'h0;
  localparam logic [1:0] CLS_WARN = 2'h1;
  localparam logic [1:0] CLS_TRIP = 2'h2;
  localparam logic [1:0] CLS_SHUT = 2'h3;

  // Display scroll dwell
  localparam int SCROLL_MS  = 2000;
  localparam int CLK_KHZ    = 25000;
  localparam int SCROLL_CYC = SCROLL_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    AAOV_IDLE = 3'b001,
    AAOV_WAIT = 3'b010,
    AAOV_ACK  = 3'b100
  } aaov_bus_e;

endpackage : aaov_pkg

//--- hdl/aaov_annunciator.sv
`timescale 1ns/1ps

module aaov_annunciator #(
  parameter int SRC_N      = aaov_pkg::SRC_COUNT,
  parameter int SCROLL_CYC = aaov_pkg::SCROLL_CYC,
  parameter int CODE_W     = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              estop_in,
  input  wire logic              override_switch,
  input  wire logic [SRC_N-1:6]  aux_fault,
  input  wire logic              engine_ctrl_warn_report,
  input  wire logic              engine_ctrl_stop_report,
  input  wire logic [CODE_W-1:0] engine_ctrl_code,
  input  wire logic [3:0]        dm1_lamp,
  input  wire logic              water_in_fuel,
  input  wire logic              after_treatment,
  input  wire logic              link_data_seen,
  output logic                   sounder,
  output logic                   summary_alarm_lamp,
  output logic                   engine_link_loss_alarm,
  output logic                   engine_stop,
  output logic                   load_open,
  output logic                   alarm_page,
  output logic                   override_notice,
  output logic                   suppressed_notice,
  output logic [3:0]             page_index,
  output logic [3:0]             page_total,
  output logic [4:0]             page_source,
  output logic [CODE_W-1:0]      page_code,
  output logic                   indication_out
);

  // ==========================================================================
  // Registers
  logic [31:0]              ctrl;
  logic [11:0]              action;
  logic [2*SRC_N-1:0]       cls;
  logic [SRC_N-1:0]         ind_map;
  logic [SRC_N-1:0]         active;
  logic [SRC_N-1:0]         cond;
  logic [3:0]               qlen;
  logic [4:0]               queue [SRC_N];
  logic [3:0]               rd_ptr;
  logic [31:0]              dwell;
  logic                     muted;
  logic [CODE_W-1:0]        code_hold;
  logic [7:0]               log_cnt;
  logic [SRC_N-1:0]         log_src;
  logic                     prev_sw;
  logic [31:0]              rdata;
  aaov_pkg::aaov_bus_e      bus_st;

  // ==========================================================================
  // override state, permanent or by switch
  wire ovr_on = ctrl[aaov_pkg::CTRL_OVR_PERM] |
                (ctrl[aaov_pkg::CTRL_OVR_SWITCH] & override_switch);

  // Categories and extra engine faults fold into the worst action
  logic [1:0] dm1_act;
  always_comb begin
    dm1_act = aaov_pkg::ACT_NONE;
    for (int i = 0; i < 6; i++) begin
      if ((i < 4 ? dm1_lamp[i] : (i == 4 ? water_in_fuel : after_treatment)) &&
          action[2*i +: 2] > dm1_act) begin
        dm1_act = action[2*i +: 2];
      end
    end
  end

  // ==========================================================================
  // Raw conditions and their classes
  always_comb begin
    cond = '0;
    cls  = '0;
    cond[aaov_pkg::SRC_ESTOP] = estop_in;
    cls[2*aaov_pkg::SRC_ESTOP +: 2] = aaov_pkg::CLS_SHUT;
    cond[aaov_pkg::SRC_OVRSW] = ctrl[aaov_pkg::CTRL_OVR_WARN] & override_switch;
    cls[2*aaov_pkg::SRC_OVRSW +: 2] = aaov_pkg::CLS_WARN;
    cond[aaov_pkg::SRC_LINK] = ctrl[aaov_pkg::CTRL_CAN_EN] & ~link_data_seen;
    cls[2*aaov_pkg::SRC_LINK +: 2] = aaov_pkg::CLS_SHUT;
    cond[aaov_pkg::SRC_ECUW] = engine_ctrl_warn_report;
    cls[2*aaov_pkg::SRC_ECUW +: 2] = aaov_pkg::CLS_WARN;
    cond[aaov_pkg::SRC_ECUS] = engine_ctrl_stop_report;
    cls[2*aaov_pkg::SRC_ECUS +: 2] = aaov_pkg::CLS_SHUT;
    cond[aaov_pkg::SRC_DM1] = (dm1_act != aaov_pkg::ACT_NONE);
    cls[2*aaov_pkg::SRC_DM1 +: 2] = dm1_act;
    for (int s = 6; s < SRC_N; s++) begin
      cond[s] = aux_fault[s];
      cls[2*s +: 2] = ind_map[s] ? aaov_pkg::CLS_IND : aaov_pkg::CLS_WARN;
    end
  end

  // ==========================================================================
  // Bus decode; a write lands on the acknowledge edge only
  wire bus_take = (bus_st == aaov_pkg::AAOV_ACK);
  wire wr_ctrl  = bus_take & avs_write & (avs_address == aaov_pkg::OFS_CTRL);
  wire wr_act   = bus_take & avs_write & (avs_address == aaov_pkg::OFS_ACTION);
  wire wr_map   = bus_take & avs_write & (avs_address == aaov_pkg::OFS_INDMAP);
  wire mute_req = wr_ctrl & avs_byteenable[0] & avs_writedata[aaov_pkg::CTRL_MUTE];
  wire warn_rst = wr_ctrl & avs_byteenable[1] &
                  avs_writedata[aaov_pkg::CTRL_RESET_WARN];
  wire log_pop  = wr_ctrl & avs_byteenable[1] & avs_writedata[aaov_pkg::CTRL_LOG_POP];

  // ==========================================================================
  // Alarm table and occurrence queue
  logic [SRC_N-1:0] is_ind;
  logic [SRC_N-1:0] next_active;
  logic [SRC_N-1:0] rise;
  genvar g;
  generate
    for (g = 0; g < SRC_N; g++) begin : g_src
      wire is_warn = (cls[2*g +: 2] == aaov_pkg::CLS_WARN);
      assign is_ind[g] = (cls[2*g +: 2] == aaov_pkg::CLS_IND);
      assign next_active[g] = ~is_ind[g] & (cond[g] |
        (active[g] & is_warn & ctrl[aaov_pkg::CTRL_LATCH_WARN] & ~warn_rst));
      assign rise[g] = next_active[g] & ~active[g];
    end
  endgenerate

  // Lowest new source wins a cycle; others enter on later cycles
  logic [4:0] new_src;
  logic       new_any;
  always_comb begin
    new_src = '0;
    new_any = 1'b0;
    for (int s = SRC_N - 1; s >= 0; s--) begin
      if (rise[s]) begin
        new_src = 5'(s);
        new_any = 1'b1;
      end
    end
  end

  // Entries whose alarm is gone are dropped; compaction keeps the order
  logic [4:0] cq [SRC_N];
  logic [3:0] clen;
  always_comb begin
    clen = '0;
    cq   = '{default: '0};
    for (int i = 0; i < SRC_N; i++) begin
      if (4'(i) < qlen && next_active[queue[i][3:0]]) begin
        cq[clen] = queue[i];
        clen = clen + 4'h1;
      end
    end
  end

  // Only one rising source is admitted per cycle so the order stays strict
  logic [SRC_N-1:0] admit;
  always_comb begin
    admit = active & next_active;
    if (new_any) begin
      admit[new_src[3:0]] = 1'b1;
    end
  end

  // ==========================================================================
  // Protective decisions
  logic stop_any, blocked;
  always_comb begin
    stop_any = 1'b0;
    blocked  = 1'b0;
    for (int s = 0; s < SRC_N; s++) begin
      if (active[s] && cls[2*s +: 2] >= aaov_pkg::CLS_TRIP) begin
        if (!ovr_on || s == aaov_pkg::SRC_ESTOP) begin
          stop_any = 1'b1;
        end else begin
          blocked = 1'b1;
        end
      end
    end
  end

  wire any_alarm = (qlen != 4'h0);
  wire [3:0] show_ptr = (rd_ptr < qlen) ? rd_ptr : 4'h0;

  // ==========================================================================
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      active <= '0;
      qlen   <= '0;
      rd_ptr <= '0;
      dwell  <= '0;
      queue  <= '{default: '0};
    end else begin
      active <= admit;
      for (int i = 0; i < SRC_N; i++) begin
        queue[i] <= (new_any && 4'(i) == clen) ? new_src : cq[i];
      end
      qlen <= clen + {3'h0, new_any};
      if (dwell >= 32'(SCROLL_CYC - 1) || rd_ptr >= qlen) begin
        dwell  <= '0;
        rd_ptr <= (show_ptr + 4'h1 >= qlen) ? 4'h0 : show_ptr + 4'h1;
      end else begin
        dwell <= dwell + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      muted     <= 1'b0;
      code_hold <= '0;
      prev_sw   <= 1'b0;
    end else begin
      // mute holds until a new alarm or until no alarm is left
      muted     <= any_alarm & (mute_req | (muted & ~new_any));
      prev_sw   <= blocked;
      if (engine_ctrl_warn_report || engine_ctrl_stop_report) begin
        code_hold <= engine_ctrl_code;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      log_cnt <= '0;
      log_src <= '0;
    end else begin
      if (ctrl[aaov_pkg::CTRL_LOG_EN] && blocked && !prev_sw) begin
        log_cnt <= log_cnt + 8'h1;
        log_src <= active;
      end else if (log_pop) begin
        log_cnt <= '0;
      end
    end
  end

  // ==========================================================================
  // Outputs, all registered
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sounder                <= 1'b0;
      summary_alarm_lamp     <= 1'b0;
      engine_link_loss_alarm <= 1'b0;
      engine_stop            <= 1'b0;
      load_open              <= 1'b0;
      alarm_page             <= 1'b0;
      override_notice        <= 1'b0;
      suppressed_notice      <= 1'b0;
      page_index             <= '0;
      page_total             <= '0;
      page_source            <= '0;
      page_code              <= '0;
      indication_out         <= 1'b0;
    end else begin
      // sounder and lamp; lamp ignores mute
      sounder            <= any_alarm & ~(muted | mute_req);
      summary_alarm_lamp <= any_alarm & ctrl[aaov_pkg::CTRL_LAMP_EN];
      engine_link_loss_alarm <= active[aaov_pkg::SRC_LINK];
      // set runs and load switch held while blocked, unless the emergency stop is active
      engine_stop        <= stop_any;
      load_open          <= stop_any;
      alarm_page         <= any_alarm;
      override_notice    <= ovr_on;
      suppressed_notice  <= blocked;
      page_index         <= any_alarm ? show_ptr + 4'h1 : 4'h0;
      page_total         <= qlen;
      page_source        <= queue[show_ptr];
      page_code          <= code_hold;
      // indication routing; no entries for them
      indication_out     <= |(cond & is_ind & ind_map);
    end
  end

  // ==========================================================================
  // Avalon slave: one wait cycle, then acknowledge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bus_st          <= aaov_pkg::AAOV_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      unique case (bus_st)
        aaov_pkg::AAOV_IDLE: begin
          if (avs_read || avs_write) begin
            bus_st <= aaov_pkg::AAOV_WAIT;
          end
        end
        aaov_pkg::AAOV_WAIT: begin
          bus_st          <= aaov_pkg::AAOV_ACK;
          avs_waitrequest <= 1'b0;
          avs_readdata    <= avs_read ? rdata : 32'h0;
        end
        aaov_pkg::AAOV_ACK: begin
          bus_st          <= aaov_pkg::AAOV_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    unique case (avs_address)
      aaov_pkg::OFS_CTRL:     rdata = {22'h0, ctrl[9:0] & 10'h07f};
      aaov_pkg::OFS_STATUS:   rdata = {24'h0, ovr_on, blocked, stop_any, muted,
                                       qlen};
      aaov_pkg::OFS_ACTION:   rdata = {20'h0, action};
      aaov_pkg::OFS_ALARM_IN: rdata = {16'h0, active};
      aaov_pkg::OFS_PAGE:     rdata = {11'h0, queue[show_ptr], 16'(code_hold)};
      aaov_pkg::OFS_LOG:      rdata = {8'h0, log_cnt, log_src};
      aaov_pkg::OFS_INDMAP:   rdata = {16'h0, ind_map};
      default:                rdata = 32'h0;
    endcase
  end

  // Command bits self-clear since they only pulse on the write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl    <= aaov_pkg::CTRL_RESET;
      action  <= aaov_pkg::ACTION_RESET;
      ind_map <= '0;
    end else begin
      if (wr_ctrl && avs_byteenable[0]) begin
        ctrl[7:0] <= avs_writedata[7:0] & 8'h7f;
      end
      if (wr_act) begin
        action <= avs_writedata[11:0];
      end
      if (wr_map) begin
        ind_map <= avs_writedata[15:0];
      end
    end
  end

endmodule : aaov_annunciator

//--- verification/aaov_checker_sva.sv
`timescale 1ns/1ps
// ==========================================================
// Checker on the annunciator ports
module aaov_checker (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       estop_in,
  input wire logic       engine_ctrl_warn_report,
  input wire logic       engine_ctrl_stop_report,
  input wire logic       sounder,
  input wire logic       summary_alarm_lamp,
  input wire logic       engine_link_loss_alarm,
  input wire logic       engine_stop,
  input wire logic       alarm_page,
  input wire logic       override_notice,
  input wire logic       suppressed_notice,
  input wire logic [3:0] page_index,
  input wire logic [3:0] page_total
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_wait_ack;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_raise;
    ##2 page_total != 4'h0;
  endsequence
  chk_ack_latency:
    assert property ($rose(avs_read || avs_write) |=> s_wait_ack) else $error("bus answer late");
  chk_ack_single:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack longer than one");
  chk_estop_stop:
    assert property (estop_in |-> ##2 engine_stop) else $error("estop did not stop");
  chk_sound_alarm:
    assert property ((sounder || summary_alarm_lamp) |-> page_total != 4'h0)
      else $error("sounder without alarm");
  chk_page_jump:
    assert property (page_total != 4'h0 |-> alarm_page) else $error("alarm page not shown");
  chk_index_range:
    assert property (page_total == 4'h0 ? page_index == 4'h0 :
                     (page_index != 4'h0 && page_index <= page_total))
      else $error("page index out of range");
  chk_mute_only:
    assert property (($fell(sounder) && page_total != 4'h0) |->
                     alarm_page && page_total == $past(page_total))
      else $error("mute changed alarms");
  chk_report_entry:
    assert property ((engine_ctrl_warn_report || engine_ctrl_stop_report) |-> s_raise)
      else $error("report made no entry");
  chk_blocked_ovr:
    assert property (suppressed_notice |-> override_notice)
      else $error("blocked without override");
  chk_link_stop:
    assert property ((engine_link_loss_alarm && !override_notice) |-> engine_stop)
      else $error("link loss did not stop");
endmodule : aaov_checker

bind aaov_annunciator aaov_checker aaov_checker_i (.*);

//--- verification/aaov_ecu_model.sv
`timescale 1ns/1ps
// ==========================================================
// Engine controller on the datalink
module aaov_ecu_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        link_up,
  input  wire logic        warn_req,
  input  wire logic        stop_req,
  input  wire logic [15:0] code_req,
  output logic             link_data_seen,
  output logic             engine_ctrl_warn_report,
  output logic             engine_ctrl_stop_report,
  output logic [15:0]      engine_ctrl_code
);
  // Code churns outside reports so a late capture shows up as junk
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      link_data_seen <= 1'b0;
      engine_ctrl_warn_report <= 1'b0;
      engine_ctrl_stop_report <= 1'b0;
      engine_ctrl_code <= 16'h0000;
    end else begin
      link_data_seen <= link_up;
      engine_ctrl_warn_report <= warn_req;
      engine_ctrl_stop_report <= stop_req;
      engine_ctrl_code <= (warn_req || stop_req) ? code_req : ~engine_ctrl_code;
    end
  end
endmodule : aaov_ecu_model

//--- verification/test_aaov_annunciator.sv
`timescale 1ns/1ps
module test_aaov_annunciator;
  // ==========================================================
  // Signals
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'h0, dm1_lamp = 4'h0, page_index, page_total;
  logic        estop_in = 1'b0, override_switch = 1'b0, water_in_fuel = 1'b0;
  logic        after_treatment = 1'b0, link_up = 1'b1, warn_req = 1'b0, stop_req = 1'b0;
  logic [15:6] aux_fault = 10'h000;
  logic [15:0] code_req = 16'h0000, engine_ctrl_code, page_code;
  logic [4:0]  page_source;
  logic        avs_waitrequest, sounder, summary_alarm_lamp, engine_link_loss_alarm;
  logic        engine_stop, load_open, alarm_page, override_notice, suppressed_notice;
  logic        indication_out, link_data_seen, engine_ctrl_warn_report, engine_ctrl_stop_report;
  int          n_fail = 0;
  int          comparisons = 0;

  always #20 clk_sys = ~clk_sys;

  // Short dwell keeps the scroll visible in a short run
  aaov_annunciator #(.SCROLL_CYC(4)) aaov_annunciator_i (.*);
  aaov_ecu_model aaov_ecu_model_i (.*);

  // ==========================================================
  // Shared tasks
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_fail++;
      conclude();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  // Report path adds one cycle in the model, two in the block
  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask : settle

  task automatic rst();
    sys_rst <= 1'b1;
    {estop_in, override_switch, water_in_fuel, after_treatment} <= 4'h0;
    {warn_req, stop_req, link_up} <= 3'h1;
    aux_fault <= 10'h000;
    dm1_lamp <= 4'h0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
  endtask : rst

  task automatic seek(input logic [3:0] idx);
    int i;
    for (i = 0; i < 40 && page_index !== idx; i++) @(posedge clk_sys);
    if (i == 40) conclude_fail();
  endtask : seek

  task automatic conclude_fail();
    n_fail++;
    conclude();
  endtask : conclude_fail

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rst();
    bus(1'b0, aaov_pkg::OFS_CTRL, 32'h0, 4'hf);
    chk(q, aaov_pkg::CTRL_RESET);
    bus(1'b0, aaov_pkg::OFS_ACTION, 32'h0, 4'hf);
    chk(q, {20'h00000, aaov_pkg::ACTION_RESET});
    bus(1'b1, 8'hfc, 32'hffff_ffff, 4'hf);
    bus(1'b0, 8'hfc, 32'h0, 4'hf);
    chk(q, 32'h0);
  endtask : t_regs

  task automatic t_mute();
    rst();
    aux_fault[6] <= 1'b1;
    settle();
    chk({sounder, summary_alarm_lamp, alarm_page}, 3'h7);
    chk({page_total, page_source}, 9'h026);
    bus(1'b1, aaov_pkg::OFS_CTRL, 32'h81, 4'h1);
    settle();
    chk(sounder, 1'b0);
    chk({summary_alarm_lamp, alarm_page, page_total}, 6'h31);
    aux_fault[6] <= 1'b0;
    settle();
    chk(page_total, 4'h0);
  endtask : t_mute

  task automatic t_scroll();
    rst();
    aux_fault[7] <= 1'b1;
    settle();
    estop_in <= 1'b1;
    settle();
    chk({page_total, engine_stop}, 5'h05);
    seek(4'h1);
    chk(page_source, 5'h07);
    seek(4'h2);
    chk(page_source, 5'h00);
  endtask : t_scroll

  task automatic t_override();
    rst();
    bus(1'b1, aaov_pkg::OFS_CTRL, 32'h23, 4'h1);
    code_req <= 16'h5a3c;
    stop_req <= 1'b1;
    settle();
    chk({engine_stop, load_open}, 2'h0);
    chk({override_notice, suppressed_notice}, 2'h3);
    chk({page_source, page_code}, {5'h04, 16'h5a3c});
    bus(1'b0, aaov_pkg::OFS_LOG, 32'h0, 4'hf);
    chk(q[23:0], 24'h01_0010);
    bus(1'b0, aaov_pkg::OFS_STATUS, 32'h0, 4'hf);
    chk(q, 32'h0000_00c1);
    bus(1'b1, aaov_pkg::OFS_CTRL, 32'h223, 4'h3);
    bus(1'b0, aaov_pkg::OFS_LOG, 32'h0, 4'hf);
    chk(q[23:16], 8'h00);
    estop_in <= 1'b1;
    settle();
    chk(engine_stop, 1'b1);
  endtask : t_override

  task automatic t_switch();
    rst();
    bus(1'b1, aaov_pkg::OFS_ACTION, 32'haaa, 4'hf);
    bus(1'b1, aaov_pkg::OFS_CTRL, 32'h0c, 4'h1);
    settle();
    chk(override_notice, 1'b0);
    override_switch <= 1'b1;
    settle();
    chk({override_notice, page_source, sounder}, 7'h43);
    chk(summary_alarm_lamp, 1'b0);
    dm1_lamp <= 4'h2;
    settle();
    chk({engine_stop, suppressed_notice, load_open}, 3'h2);
    chk(page_total, 4'h2);
  endtask : t_switch

  task automatic t_ecu();
    rst();
    bus(1'b1, aaov_pkg::OFS_ACTION, 32'h300, 4'hf);
    after_treatment <= 1'b1;
    settle();
    chk(page_total, 4'h0);
    water_in_fuel <= 1'b1;
    settle();
    chk({page_total, engine_stop}, 5'h03);
    code_req <= 16'h0042;
    warn_req <= 1'b1;
    settle();
    chk(page_total, 4'h2);
    chk(page_code, 16'h0042);
  endtask : t_ecu

  task automatic t_link();
    int i;
    rst();
    bus(1'b1, aaov_pkg::OFS_CTRL, 32'h41, 4'h1);
    repeat (50) @(posedge clk_sys);
    chk(engine_link_loss_alarm, 1'b0);
    link_up <= 1'b0;
    for (i = 0; i < 1000 && engine_link_loss_alarm !== 1'b1; i++) @(posedge clk_sys);
    if (i == 1000) conclude_fail();
    settle();
    chk(engine_stop, 1'b1);
  endtask : t_link

  task automatic t_ind_latch();
    rst();
    bus(1'b1, aaov_pkg::OFS_INDMAP, 32'h0000_0100, 4'hf);
    aux_fault[8] <= 1'b1;
    settle();
    chk({indication_out, page_total, sounder}, 6'h20);
    bus(1'b1, aaov_pkg::OFS_CTRL, 32'h11, 4'h1);
    aux_fault[9] <= 1'b1;
    settle();
    aux_fault[9] <= 1'b0;
    settle();
    chk(page_total, 4'h1);
    bus(1'b1, aaov_pkg::OFS_CTRL, 32'h111, 4'h3);
    settle();
    chk(page_total, 4'h0);
  endtask : t_ind_latch

  initial begin
    t_regs();
    t_mute();
    t_scroll();
    t_override();
    t_switch();
    t_ecu();
    t_link();
    t_ind_latch();
    conclude();
  end
endmodule : test_aaov_annunciator
